// >>> rtl/mfs_pkg.sv
// constants and types for the mac frame statistics counters
package mfs_pkg;
    localparam logic [7:0] OFF_OVRN = 8'h00;
    localparam logic [7:0] OFF_RSYM = 8'h04;
    localparam logic [7:0] OFF_OCLN = 8'h08;
    localparam logic [7:0] OFF_OERR = 8'h0c;
    localparam logic [7:0] OFF_UNDR = 8'h10;
    localparam logic [7:0] OFF_CTST = 8'h14;
    localparam logic [7:0] OFF_LMIS = 8'h18;
    localparam logic [7:0] OFF_TPSE = 8'h1c;
    localparam logic [7:0] OFF_TUNR = 8'h20;
    localparam logic [7:0] OFF_FCS = 8'h24;
    localparam logic [7:0] OFF_ALN = 8'h28;
    localparam logic [7:0] OFF_CFG = 8'h2c;
    localparam logic [7:0] OFF_ISR = 8'h30;
    localparam logic [7:0] OFF_IMR = 8'h34;
    localparam int CFG_BIG_BIT = 8;
    localparam int CFG_JUMBO_BIT = 3;
    localparam int CFG_HALF_BIT = 4;
    localparam int CFG_LCHK_BIT = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [13:0] LEN_MIN = 14'h0040;
    localparam logic [13:0] LEN_STD = 14'h05ee;
    localparam logic [13:0] LEN_BIG = 14'h0600;
    localparam logic [13:0] LEN_JUMBO = 14'h2800;
    localparam logic [15:0] TYPE_MIN = 16'h0600;
    // 96 bit times; at 10 Mb/s that is 9600 ns, the slowest link
    localparam int SQE_WINDOW_NS = 9600;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SQE_WINDOW_CYC = SQE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int NUM_EVT = 11;
    typedef struct packed {
        logic done;
        logic [13:0] len;
        logic [15:0] len_field;
        logic crc_err;
        logic odd_bits;
        logic sym_err;
        logic addr_match;
        logic dma_overrun;
    } mfs_rx_s;
    typedef struct packed {
        logic done;
        logic underrun;
        logic pause;
    } mfs_tx_s;
    typedef enum logic [2:0] {
        SQE_IDLE = 3'b001,
        SQE_WAIT = 3'b010,
        SQE_SEEN = 3'b100
    } mfs_sqe_e;
endpackage

// >>> rtl/mfs_stats.sv
// statistics counters block with apb slave and interrupt
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module mfs_stats #(
    parameter int SQE_CYC = mfs_pkg::SQE_WINDOW_CYC
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame engines
    input wire mfs_pkg::mfs_rx_s rx_evt,
    input wire mfs_pkg::mfs_tx_s tx_evt,
    // mii pins
    input wire logic tx_en,
    input wire logic col,
    // interrupt
    output logic irq
);
    import mfs_pkg::*;

    logic [7:0] ovrn_reg, rsym_reg, ocln_reg, oerr_reg, undr_reg;
    logic [7:0] ctst_reg, lmis_reg, tunr_reg, fcs_reg, aln_reg;
    logic [15:0] tpse_reg;
    logic [31:0] cfg_reg;
    logic [NUM_EVT-1:0] isr_reg, imr_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg;
    logic [2:0] en_s1_reg;
    logic [2:0] col_s1_reg;
    logic txen_q_reg, col_q_reg;
    mfs_sqe_e sqe_reg;
    logic [15:0] sqe_cnt_reg;

    function automatic logic [7:0] inc8(input logic [7:0] v, input logic hit);
        inc8 = hit ? v + 8'h01 : v;
    endfunction

    // pin sync: change counts once second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_s1_reg <= 3'h0;
            col_s1_reg <= 3'h0;
            txen_q_reg <= 1'b0;
            col_q_reg <= 1'b0;
        end else begin
            en_s1_reg <= {en_s1_reg[1:0], tx_en};
            col_s1_reg <= {col_s1_reg[1:0], col};
            if (en_s1_reg[1] == en_s1_reg[2]) begin
                txen_q_reg <= en_s1_reg[2];
            end
            if (col_s1_reg[1] == col_s1_reg[2]) begin
                col_q_reg <= col_s1_reg[2];
            end
        end
    end
    // length classification
    wire big_en = cfg_reg[CFG_BIG_BIT];
    wire jumbo_en = cfg_reg[CFG_JUMBO_BIT];
    wire half_dup = cfg_reg[CFG_HALF_BIT];
    wire lchk_en = cfg_reg[CFG_LCHK_BIT];
    wire [13:0] max_len = jumbo_en ? LEN_JUMBO : (big_en ? LEN_BIG : LEN_STD);
    wire rx_done = rx_evt.done;
    wire any_err = rx_evt.crc_err | rx_evt.sym_err;
    wire too_long = rx_evt.len > max_len;
    wire too_short = rx_evt.len < LEN_MIN;
    wire valid_len = !too_long && !too_short;
    wire hit_ovrn = rx_done && rx_evt.addr_match && rx_evt.dma_overrun;
    wire hit_rsym = rx_done && rx_evt.sym_err;
    wire hit_fcs = rx_done && valid_len && any_err && !rx_evt.odd_bits;
    wire hit_aln = rx_done && valid_len && any_err && rx_evt.odd_bits;
    wire hit_ocln = rx_done && too_long && !any_err;
    wire hit_oerr = rx_done && too_long && any_err;
    wire hit_undr = rx_done && too_short && !any_err;
    wire is_len = rx_evt.len_field < TYPE_MIN;
    wire hit_lmis = rx_done && lchk_en && is_len && !too_long
        && ({2'b00, rx_evt.len} < rx_evt.len_field);
    wire hit_tunr = tx_evt.done && tx_evt.underrun;
    wire hit_tpse = tx_evt.done && tx_evt.pause && !tx_evt.underrun;
    wire hit_ctst;

    // sqe test watch after tx enable falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sqe_reg <= SQE_IDLE;
            sqe_cnt_reg <= 16'h0000;
        end else begin
            case (sqe_reg)
                SQE_IDLE: begin
                    if (txen_q_reg) begin
                        sqe_reg <= SQE_SEEN;
                    end
                end
                SQE_SEEN: begin
                    sqe_cnt_reg <= 16'h0000;
                    if (!txen_q_reg) begin
                        sqe_reg <= half_dup ? SQE_WAIT : SQE_IDLE;
                    end
                end
                SQE_WAIT: begin
                    sqe_cnt_reg <= sqe_cnt_reg + 16'h0001;
                    if (col_q_reg || txen_q_reg || sqe_cnt_reg == 16'(SQE_CYC - 1)) begin
                        sqe_reg <= txen_q_reg ? SQE_SEEN : SQE_IDLE;
                    end
                end
                default: sqe_reg <= SQE_IDLE;
            endcase
        end
    end
    assign hit_ctst = sqe_reg == SQE_WAIT && !col_q_reg && !txen_q_reg
        && sqe_cnt_reg == 16'(SQE_CYC - 1);

    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire mapped = paddr <= OFF_IMR && paddr[1:0] == 2'b00;
    wire w_ovrn = wr && paddr == OFF_OVRN;
    wire w_rsym = wr && paddr == OFF_RSYM;
    wire w_ocln = wr && paddr == OFF_OCLN;
    wire w_oerr = wr && paddr == OFF_OERR;
    wire w_undr = wr && paddr == OFF_UNDR;
    wire w_ctst = wr && paddr == OFF_CTST;
    wire w_lmis = wr && paddr == OFF_LMIS;
    wire w_tpse = wr && paddr == OFF_TPSE;
    wire w_tunr = wr && paddr == OFF_TUNR;
    wire w_fcs = wr && paddr == OFF_FCS;
    wire w_aln = wr && paddr == OFF_ALN;
    wire w_cfg = wr && paddr == OFF_CFG;
    wire w_imr = wr && paddr == OFF_IMR;
    wire r_isr = rd && paddr == OFF_ISR;
    wire [NUM_EVT-1:0] evt = {hit_aln, hit_fcs, hit_tunr, hit_tpse, hit_lmis, hit_ctst,
        hit_undr, hit_oerr, hit_ocln, hit_rsym, hit_ovrn};
    logic [31:0] rd_mux;
    always_comb begin
        if (paddr == OFF_OVRN) rd_mux = {24'h0, ovrn_reg};
        else if (paddr == OFF_RSYM) rd_mux = {24'h0, rsym_reg};
        else if (paddr == OFF_OCLN) rd_mux = {24'h0, ocln_reg};
        else if (paddr == OFF_OERR) rd_mux = {24'h0, oerr_reg};
        else if (paddr == OFF_UNDR) rd_mux = {24'h0, undr_reg};
        else if (paddr == OFF_CTST) rd_mux = {24'h0, ctst_reg};
        else if (paddr == OFF_LMIS) rd_mux = {24'h0, lmis_reg};
        else if (paddr == OFF_TPSE) rd_mux = {16'h0, tpse_reg};
        else if (paddr == OFF_TUNR) rd_mux = {24'h0, tunr_reg};
        else if (paddr == OFF_FCS) rd_mux = {24'h0, fcs_reg};
        else if (paddr == OFF_ALN) rd_mux = {24'h0, aln_reg};
        else if (paddr == OFF_CFG) rd_mux = cfg_reg;
        else if (paddr == OFF_ISR) rd_mux = {21'h0, isr_reg};
        else if (paddr == OFF_IMR) rd_mux = {21'h0, imr_reg};
        else rd_mux = 32'h0000_0000;
    end

    // counters: software write wins over a same-cycle increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovrn_reg <= 8'h00;
            rsym_reg <= 8'h00;
            ocln_reg <= 8'h00;
            oerr_reg <= 8'h00;
            undr_reg <= 8'h00;
            ctst_reg <= 8'h00;
            lmis_reg <= 8'h00;
            tpse_reg <= 16'h0000;
            tunr_reg <= 8'h00;
            fcs_reg <= 8'h00;
            aln_reg <= 8'h00;
        end else begin
            ovrn_reg <= w_ovrn ? pwdata[7:0] : inc8(ovrn_reg, hit_ovrn);
            rsym_reg <= w_rsym ? pwdata[7:0] : inc8(rsym_reg, hit_rsym);
            ocln_reg <= w_ocln ? pwdata[7:0] : inc8(ocln_reg, hit_ocln);
            oerr_reg <= w_oerr ? pwdata[7:0] : inc8(oerr_reg, hit_oerr);
            undr_reg <= w_undr ? pwdata[7:0] : inc8(undr_reg, hit_undr);
            ctst_reg <= w_ctst ? pwdata[7:0] : inc8(ctst_reg, hit_ctst);
            lmis_reg <= w_lmis ? pwdata[7:0] : inc8(lmis_reg, hit_lmis);
            tunr_reg <= w_tunr ? pwdata[7:0] : inc8(tunr_reg, hit_tunr);
            fcs_reg <= w_fcs ? pwdata[7:0] : inc8(fcs_reg, hit_fcs);
            aln_reg <= w_aln ? pwdata[7:0] : inc8(aln_reg, hit_aln);
            if (w_tpse) begin
                tpse_reg <= pwdata[15:0];
            end else if (hit_tpse) begin
                tpse_reg <= tpse_reg + 16'h0001;
            end
        end
    end

    // config, interrupt and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET;
            imr_reg <= '0;
            isr_reg <= '0;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            if (w_cfg) begin
                cfg_reg <= pwdata;
            end
            if (w_imr) begin
                imr_reg <= pwdata[NUM_EVT-1:0];
            end
            // new event beats the read clear
            isr_reg <= (r_isr && !pready_reg ? '0 : isr_reg) | evt;
            irq_reg <= |(isr_reg & imr_reg);
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            prdata_reg <= (rd && !pready_reg) ? rd_mux : 32'h0000_0000;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

    // checks
    undr_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_undr && !w_undr |=> undr_reg == $past(undr_reg) + 8'h01)
        else $error("undersize counter missed");
    oerr_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_oerr && !w_oerr |=> oerr_reg == $past(oerr_reg) + 8'h01)
        else $error("jabber counter missed");
    ocln_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && any_err && !w_ocln |=> $stable(ocln_reg))
        else $error("errored frame counted clean");
    maxlen_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rx_evt.len == 14'h05ef && !big_en && !jumbo_en && !any_err
        |=> ocln_reg != $past(ocln_reg) || $past(w_ocln))
        else $error("1519 byte frame not oversize");
    lmis_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !lchk_en && !w_lmis |=> $stable(lmis_reg))
        else $error("mismatch counted while disabled");
    type_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rx_evt.len_field >= TYPE_MIN && !w_lmis |=> $stable(lmis_reg))
        else $error("type frame counted as mismatch");
    underrun_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_evt.done && tx_evt.underrun && !w_tpse |=> $stable(tpse_reg))
        else $error("underrun frame touched pause count");
    sym_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_rsym && !w_rsym |=> rsym_reg == $past(rsym_reg) + 8'h01)
        else $error("symbol error counter missed");
    ovrn_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_ovrn && !w_ovrn |=> ovrn_reg == $past(ovrn_reg) + 8'h01)
        else $error("overrun counter missed");
    apb_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    jab_cv: cover property (@(posedge pclk) disable iff (!presetn) hit_oerr);
    sqe_cv: cover property (@(posedge pclk) disable iff (!presetn) hit_ctst);
    lmis_cv: cover property (@(posedge pclk) disable iff (!presetn) hit_lmis);
    irq_cv: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule
`default_nettype wire

// >>> verif/mfs_phy_model.sv
// phy-side model that answers the collision test after each transmission
`timescale 1ns/100ps
`default_nettype none
module mfs_phy_model (
    // mii
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_en,
    output logic col,
    // scenario control
    input wire logic sqe_on
);
    logic tx_d;
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_d <= 1'b0;
            cnt <= 0;
            col <= 1'b0;
        end else begin
            tx_d <= tx_en;
            if (tx_d && !tx_en && sqe_on) begin
                cnt <= 10;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            // pulse held 6 cycles so the agree filter cannot drop it
            col <= cnt > 0 && cnt <= 6;
        end
    end
endmodule
`default_nettype wire

// >>> verif/mfs_stats_tb_top.sv
// self-checking bench for the frame statistics counters
`timescale 1ns/100ps
`default_nettype none
module mfs_stats_tb_top;
    import mfs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, tx_en, col, sqe_on, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    mfs_rx_s rx_evt, r;
    mfs_tx_s tx_evt;
    int n_fail, samples_checked, seed, exp_cnt[11];
    int lt[8] = '{63, 64, 1518, 1519, 1536, 1537, 10240, 10241};
    mfs_stats #(.SQE_CYC(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .tx_evt(tx_evt), .tx_en(tx_en),
        .col(col), .irq(irq));
    mfs_phy_model phy_u (.pclk(pclk), .presetn(presetn), .tx_en(tx_en), .col(col),
        .sqe_on(sqe_on));
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set_cfg(input logic [31:0] v);
        cfg = v;
        apb(1'b1, OFF_CFG, v);
    endtask
    function automatic logic [10:0] evt_of(input mfs_rx_s f, input logic [31:0] c);
        logic [13:0] mx;
        logic er, ov, ok;
        logic [10:0] e;
        mx = c[CFG_JUMBO_BIT] ? LEN_JUMBO : (c[CFG_BIG_BIT] ? LEN_BIG : LEN_STD);
        er = f.crc_err | f.sym_err;
        ov = f.len > mx;
        ok = !ov && f.len >= LEN_MIN;
        e = '0;
        e[0] = f.addr_match & f.dma_overrun;
        e[1] = f.sym_err;
        e[2] = ov & !er;
        e[3] = ov & er;
        e[4] = f.len < LEN_MIN && !er;
        e[6] = c[CFG_LCHK_BIT] && f.len < f.len_field && f.len_field < TYPE_MIN && !ov;
        e[9] = er & ok & !f.odd_bits;
        e[10] = er & ok & f.odd_bits;
        return e;
    endfunction
    task automatic rx_frame(input mfs_rx_s f);
        logic [10:0] e;
        e = evt_of(f, cfg);
        @(posedge pclk);
        rx_evt <= f;
        @(posedge pclk);
        rx_evt.done <= 1'b0;
        for (int i = 0; i < 11; i++) exp_cnt[i] += e[i];
    endtask
    task automatic tx_frame(input logic und, input logic pau);
        @(posedge pclk);
        tx_evt <= '{done: 1'b1, underrun: und, pause: pau};
        @(posedge pclk);
        tx_evt.done <= 1'b0;
        exp_cnt[7] += pau & !und;
        exp_cnt[8] += und;
    endtask
    task automatic sqe_frame(input logic answer);
        @(posedge pclk);
        sqe_on <= answer;
        tx_en <= 1'b1;
        repeat (8) @(posedge pclk);
        tx_en <= 1'b0;
        repeat (40) @(posedge pclk);
        exp_cnt[5] += !answer && cfg[CFG_HALF_BIT];
    endtask
    task automatic chk_all();
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, 8'(4 * i), '0);
            chk(rd, 32'(exp_cnt[i]) & (i == 7 ? 32'hffff : 32'hff));
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, tx_en, sqe_on} = '0;
        {paddr, pwdata, cfg} = '0;
        rx_evt = '0;
        tx_evt = '0;
        seed = 8;
        n_fail = 0;
        samples_checked = 0;
        exp_cnt = '{default: 0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        apb(1'b0, 8'h38, 32'h0);
        chk({31'h0, perr}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFF_OVRN, 32'hffff_ffff);
        apb(1'b0, OFF_OVRN, 32'h0);
        chk(rd, 32'h0000_00ff);
        apb(1'b1, OFF_TPSE, 32'hffff_ffff);
        apb(1'b0, OFF_TPSE, 32'h0);
        chk(rd, 32'h0000_ffff);
        apb(1'b1, OFF_OVRN, 32'h0);
        apb(1'b1, OFF_TPSE, 32'h0);
        for (int n = 0; n < 60; n++) begin
            if (n % 10 == 0) begin
                set_cfg(((n >= 30) ? (32'h1 << CFG_LCHK_BIT) : 32'h0)
                    | (((n / 10) % 3 == 1) ? (32'h1 << CFG_BIG_BIT) : 32'h0)
                    | (((n / 10) % 3 == 2) ? (32'h1 << CFG_JUMBO_BIT) : 32'h0));
            end
            r = '0;
            r.done = 1'b1;
            r.len = 14'(lt[$unsigned($random(seed)) % 8]);
            if ($random(seed) & 1) r.len = 14'($unsigned($random(seed)) % 1600);
            r.len_field = 16'($unsigned($random(seed)) % 1600);
            {r.crc_err, r.odd_bits, r.sym_err} = 3'($random(seed) & $random(seed));
            r.addr_match = 1'($random(seed));
            r.dma_overrun = 1'($random(seed));
            if ($random(seed) % 5 == 0) begin
                r = '{done: 1'b1, len: 14'h0064, len_field: 16'h0800, addr_match: 1'b1,
                    dma_overrun: 1'b1, default: 1'b0};
            end
            rx_frame(r);
        end
        chk_all();
        r = '{done: 1'b1, len: 14'h0064, len_field: 16'h0800, addr_match: 1'b1,
            dma_overrun: 1'b1, default: 1'b0};
        apb(1'b0, OFF_ISR, 32'h0);
        apb(1'b1, OFF_IMR, 32'h1);
        rx_frame(r);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, OFF_ISR, 32'h0);
        chk(rd, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFF_IMR, 32'h0);
        rx_frame(r);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, OFF_ISR, 32'h0);
        chk(rd, 32'h1);
        tx_frame(1'b0, 1'b1);
        tx_frame(1'b0, 1'b1);
        tx_frame(1'b1, 1'b1);
        tx_frame(1'b1, 1'b0);
        set_cfg(32'h1 << CFG_HALF_BIT);
        sqe_frame(1'b1);
        sqe_frame(1'b0);
        sqe_frame(1'b0);
        set_cfg(32'h0);
        sqe_frame(1'b0);
        chk_all();
        close_out();
    end
endmodule
`default_nettype wire
